// ==== rtl/cpm_core.sv ====
// Cascaded position, velocity and current PI control core with APB registers
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module cpm_core
	import cpm_pkg::*;
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     clk_en,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [AW-1:0]            paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     ctrl_tick,
	input  wire logic signed [DW-1:0]     pos_demand,
	input  wire logic signed [DW-1:0]     ramp_vel,
	input  wire logic signed [DW-1:0]     ramp_acc,
	input  wire logic signed [DW-1:0]     torque_demand,
	input  wire logic [NS-1:0][DW-1:0]    pos_fb,
	input  wire logic [NS-1:0][DW-1:0]    vel_fb,
	input  wire logic [NS-1:0]            sensor_aligned,
	input  wire logic signed [DW-1:0]     cur_actual,
	output logic signed [DW-1:0]          pwm_duty,
	output logic signed [DW-1:0]          vel_setpoint,
	output logic signed [DW-1:0]          cur_setpoint,
	output logic [1:0]                    comm_sensor,
	output logic                          align_req,
	output logic                          cycle_done
);

	logic [7:0]              submode;
	cpm_mode_e               op_mode;
	logic [1:0]              legacy_sel;
	logic [DW-1:0]           ff_vel;
	logic [DW-1:0]           ff_acc;
	logic [DW-1:0]           inertia;
	logic [DW-1:0]           ff_volt;
	logic [DW-1:0]           rated_v;
	logic [23:0]             fb_mask;
	logic [DW-1:0]           kp     [NL];
	logic [DW-1:0]           tn     [NL];
	logic [DW-1:0]           emax   [NL];
	logic [DW-1:0]           ymax   [NL];
	logic [DW-1:0]           lkp    [NL];
	logic [DW-1:0]           ltn    [NL];
	logic signed [47:0]      acc    [NL];
	logic signed [DW-1:0]    pos_out;
	logic                    converted;
	cpm_state_e              state;
	cpm_state_e              next_state;

	// Sensor scan giving sensor 1 priority over sensor 2; sensorless entry is the fallback
	function automatic logic [1:0] first_sensor(input logic [23:0] m, input int b);
		logic [1:0] r;
		r = 2'd0;
		for (int s = NS - 1; s >= 1; s--) begin
			if (m[8*s + b])
				r = 2'(s);
		end
		return r;
	endfunction

	function automatic logic signed [DW-1:0] clamp(input logic signed [47:0] v,
			input logic [DW-1:0] lim);
		logic signed [47:0] l;
		l = 48'(lim);
		if (v > l)
			return lim;
		else if (v < -l)
			return -lim;
		return v[DW-1:0];
	endfunction

	function automatic logic signed [47:0] scale_pm(input logic signed [DW-1:0] v,
			input logic [DW-1:0] f);
		return 48'((64'(v) * $signed(64'(f))) / PERMILLE);
	endfunction

	// Operating mode decode
	logic torque_md;
	logic pos_md;
	logic velt_md;
	logic closed;
	logic pos_run;
	logic vel_run;
	logic use_legacy;

	assign torque_md = (op_mode == MD_TQ) || (op_mode == MD_CST);
	assign pos_md    = (op_mode == MD_PP) || (op_mode == MD_HM) || (op_mode == MD_IP)
	                || (op_mode == MD_CSP) || (op_mode == MD_CD);
	assign velt_md   = (op_mode == MD_VL) || (op_mode == MD_PV) || (op_mode == MD_CSV);
	assign closed    = submode[SM_CLOSED];
	assign pos_run   = pos_md || (velt_md && submode[SM_POSLOOP]);
	assign vel_run   = !(torque_md && submode[SM_RTORQ]);
	assign use_legacy = closed ? legacy_sel[LG_CL] : legacy_sel[LG_OL];

	// Feedback selection
	logic [1:0] pos_sel;
	logic [1:0] vel_sel;
	logic [1:0] com_first;
	logic [1:0] com_good;
	logic       com_found;

	assign pos_sel = first_sensor(fb_mask, FB_POS);
	assign vel_sel = first_sensor(fb_mask, FB_VEL);
	assign com_first = first_sensor(fb_mask, FB_COM);

	always_comb begin
		com_good  = 2'd0;
		com_found = 1'b0;
		for (int s = NS - 1; s >= 1; s--) begin
			if (fb_mask[8*s + FB_COM] && sensor_aligned[s]) begin
				com_good  = 2'(s);
				com_found = 1'b1;
			end
		end
	end

	// Feed-forward terms
	logic signed [47:0] vff;
	logic signed [47:0] aff;
	logic signed [47:0] uff;

	assign vff = pos_run ? scale_pm(ramp_vel, ff_vel) : 48'sd0;
	assign aff = torque_md ? 48'sd0
	           : 48'((64'(scale_pm(ramp_acc, ff_acc)) * $signed(64'(inertia)))
	           / PERMILLE);
	assign uff = 48'((64'(rated_v) * 64'(ff_volt)) / PERMILLE);

	// Shared PI datapath, one loop per state
	int                 li;
	logic signed [47:0] set_v;
	logic signed [47:0] act_v;
	logic signed [47:0] err;
	logic signed [47:0] pterm;
	logic signed [47:0] acc_nx;
	logic signed [47:0] acc_lim;
	logic signed [47:0] iterm;
	logic signed [47:0] ffterm;
	logic signed [DW-1:0] y;
	logic [DW-1:0]      kp_e;
	logic [DW-1:0]      tn_e;

	always_comb begin
		li = L_CUR;
		set_v = 48'sd0;
		act_v = 48'sd0;
		ffterm = 48'sd0;
		case (state)
			ST_POS: begin
				li = L_POS;
				set_v = 48'(pos_demand);
				act_v = 48'($signed(pos_fb[pos_sel]));
			end
			ST_VEL: begin
				li = L_VEL;
				set_v = pos_run ? 48'(pos_out) + vff : 48'(ramp_vel);
				act_v = 48'($signed(vel_fb[vel_sel]));
			end
			default: begin
				li = L_CUR;
				if (torque_md)
					set_v = 48'(torque_demand);
				else if (!closed)
					set_v = 48'(ymax[L_VEL]); // Open loop drives full current
				else
					set_v = 48'(vel_setpoint) + aff;
				act_v = 48'(cur_actual);
				ffterm = uff;
			end
		endcase
		kp_e = use_legacy ? lkp[li] : kp[li];
		tn_e = use_legacy ? ltn[li] : tn[li];
		err = set_v - act_v;
		// Gain in percent: full gain at maximum deviation gives maximum output
		if (emax[li] == '0)
			pterm = 48'sd0;
		else
			// Every operand signed, else negative deviations divide as unsigned
			pterm = 48'((64'(err) * $signed(64'(kp_e)) * $signed(64'(ymax[li])))
			      / ($signed(64'(emax[li])) * PCT));
		acc_lim = 48'(64'(ymax[li]) * 64'(tn_e));
		acc_nx = acc[li] + pterm;
		if (acc_nx > acc_lim)
			acc_nx = acc_lim;
		else if (acc_nx < -acc_lim)
			acc_nx = -acc_lim;
		if (tn_e == '0) begin
			acc_nx = 48'sd0;
			iterm  = 48'sd0;
		end else begin
			iterm = acc_nx / $signed(48'(tn_e));
		end
		y = clamp(pterm + iterm + ffterm, ymax[li]);
	end

	// Control cycle sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (ctrl_tick)
					next_state = pos_run ? ST_POS : (vel_run ? ST_VEL : ST_CUR);
			end
			ST_POS:  next_state = vel_run ? ST_VEL : ST_CUR;
			ST_VEL:  next_state = ST_CUR;
			ST_CUR:  next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= ST_IDLE;
		else if (clk_en)
			state <= next_state;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int l = 0; l < NL; l++)
				acc[l] <= 48'sd0;
		end else if (clk_en) begin
			if (state != ST_IDLE)
				acc[li] <= acc_nx;
			if (!pos_run)
				acc[L_POS] <= 48'sd0;
			if (!vel_run)
				acc[L_VEL] <= 48'sd0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_out      <= '0;
			vel_setpoint <= '0;
			cur_setpoint <= '0;
			pwm_duty     <= '0;
			cycle_done   <= 1'b0;
		end else if (clk_en) begin
			cycle_done <= (state == ST_CUR);
			if (!pos_run)
				pos_out <= '0;
			case (state)
				ST_POS: pos_out <= y;
				ST_VEL: vel_setpoint <= y;
				ST_CUR: begin
					cur_setpoint <= set_v[DW-1:0];
					pwm_duty     <= y;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comm_sensor <= 2'd0;
			align_req   <= 1'b0;
		end else if (clk_en) begin
			comm_sensor <= com_found ? com_good : com_first;
			align_req   <= closed && !com_found;
		end
	end

	// APB slave, zero wait states
	logic        wr_en;
	logic        gain_hit;
	int          gl;
	int          gf;
	logic [AW-1:0] goff;

	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite && clk_en;
	assign goff   = paddr - A_GAIN;
	assign gl     = int'(goff / GAIN_STEP);
	assign gf     = int'(goff[4:2]);
	assign gain_hit = (paddr >= A_GAIN) && (paddr < A_GAIN_END) && (paddr[1:0] == 2'b00)
	               && (gf <= F_LTN);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			submode    <= SUBMODE_RST;
			op_mode    <= MD_NONE;
			legacy_sel <= LEGACY_RST;
			ff_vel     <= '0;
			ff_acc     <= '0;
			inertia    <= '0;
			ff_volt    <= FF_VOLT_RST;
			rated_v    <= '0;
			fb_mask    <= FB_MASK_RST;
		end else if (wr_en) begin
			if (paddr == A_SUBMODE)
				submode <= pwdata[7:0];
			else if (paddr == A_OPMODE)
				op_mode <= cpm_mode_e'(pwdata[3:0]);
			else if (paddr == A_LEGACY)
				legacy_sel <= pwdata[1:0];
			else if (paddr == A_FF_VEL)
				ff_vel <= pwdata[DW-1:0];
			else if (paddr == A_FF_ACC)
				ff_acc <= pwdata[DW-1:0];
			else if (paddr == A_INERTIA)
				inertia <= pwdata[DW-1:0];
			else if (paddr == A_FF_VOLT)
				ff_volt <= pwdata[DW-1:0];
			else if (paddr == A_RATED_V)
				rated_v <= pwdata[DW-1:0];
			else if (paddr == A_FB_MASK)
				fb_mask <= pwdata[23:0];
		end
	end

	// Gain tables; legacy values copied into the new set once after reset
	generate
		for (genvar g = 0; g < NL; g++) begin : g_gain
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					kp[g]   <= KP_RST;
					tn[g]   <= TN_RST;
					emax[g] <= EMAX_RST;
					ymax[g] <= YMAX_RST;
					lkp[g]  <= KP_RST;
					ltn[g]  <= TN_RST;
				end else if (clk_en) begin
					if (!converted) begin
						kp[g] <= lkp[g];
						tn[g] <= ltn[g];
					end else if (wr_en && gain_hit && gl == g) begin
						case (gf)
							F_KP:    kp[g]   <= pwdata[DW-1:0];
							F_TN:    tn[g]   <= pwdata[DW-1:0];
							F_EMAX:  emax[g] <= pwdata[DW-1:0];
							F_YMAX:  ymax[g] <= pwdata[DW-1:0];
							F_LKP:   lkp[g]  <= pwdata[DW-1:0];
							default: ltn[g]  <= pwdata[DW-1:0];
						endcase
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			converted <= 1'b0;
		else if (clk_en)
			converted <= 1'b1;
	end

	always_comb begin
		prdata  = '0;
		pslverr = 1'b0;
		if (paddr == A_SUBMODE)
			prdata = 32'(submode);
		else if (paddr == A_OPMODE)
			prdata = 32'(op_mode);
		else if (paddr == A_LEGACY)
			prdata = 32'(legacy_sel);
		else if (paddr == A_FF_VEL)
			prdata = 32'(ff_vel);
		else if (paddr == A_FF_ACC)
			prdata = 32'(ff_acc);
		else if (paddr == A_INERTIA)
			prdata = 32'(inertia);
		else if (paddr == A_FF_VOLT)
			prdata = 32'(ff_volt);
		else if (paddr == A_RATED_V)
			prdata = 32'(rated_v);
		else if (paddr == A_STATUS)
			prdata = {20'h0_0000, comm_sensor, align_req, use_legacy,
			          2'(state), vel_sel, pos_sel, vel_run, pos_run};
		else if (paddr == A_PWM)
			prdata = 32'($unsigned(pwm_duty));
		else if (paddr == A_FB_MASK)
			prdata = 32'(fb_mask);
		else if (gain_hit) begin
			case (gf)
				F_KP:    prdata = 32'(kp[gl]);
				F_TN:    prdata = 32'(tn[gl]);
				F_EMAX:  prdata = 32'(emax[gl]);
				F_YMAX:  prdata = 32'(ymax[gl]);
				F_LKP:   prdata = 32'(lkp[gl]);
				default: prdata = 32'(ltn[gl]);
			endcase
		end else
			pslverr = psel && penable;
	end

endmodule

// ==== include/cpm_pkg.sv ====
// Constants, register map and types for the cascaded PI motor control core
package cpm_pkg;
	localparam int NS = 3;
	localparam int NL = 3;
	localparam int DW = 16;
	localparam int AW = 16;
	// Loop indices
	localparam int L_POS = 0;
	localparam int L_VEL = 1;
	localparam int L_CUR = 2;
	// Register byte addresses
	localparam logic [AW-1:0] A_SUBMODE  = 16'h0000;
	localparam logic [AW-1:0] A_OPMODE   = 16'h0004;
	localparam logic [AW-1:0] A_LEGACY   = 16'h0008;
	localparam logic [AW-1:0] A_FF_VEL   = 16'h000C;
	localparam logic [AW-1:0] A_FF_ACC   = 16'h0010;
	localparam logic [AW-1:0] A_INERTIA  = 16'h0014;
	localparam logic [AW-1:0] A_FF_VOLT  = 16'h0018;
	localparam logic [AW-1:0] A_RATED_V  = 16'h001C;
	localparam logic [AW-1:0] A_STATUS   = 16'h0020;
	localparam logic [AW-1:0] A_PWM      = 16'h0024;
	localparam logic [AW-1:0] A_GAIN     = 16'h0040;
	localparam logic [AW-1:0] GAIN_STEP  = 16'h0020;
	localparam logic [AW-1:0] A_GAIN_END = 16'h00A0;
	// Feedback assignment mask: index as printed, byte address four times it
	localparam logic [AW-1:0] IDX_FB_MASK = 16'h3203;
	localparam logic [AW-1:0] A_FB_MASK   = 16'hC80C;
	// Gain block fields, word index inside a loop block
	localparam int F_KP   = 0;
	localparam int F_TN   = 1;
	localparam int F_EMAX = 2;
	localparam int F_YMAX = 3;
	localparam int F_LKP  = 4;
	localparam int F_LTN  = 5;
	// Submode select bits
	localparam int SM_CLOSED  = 0;
	localparam int SM_POSLOOP = 1;
	localparam int SM_ALIGN   = 4;
	localparam int SM_RTORQ   = 5;
	// Feedback mask bits
	localparam int FB_POS = 0;
	localparam int FB_VEL = 1;
	localparam int FB_COM = 2;
	// Legacy select bits (closed loop subindex 07, open loop subindex 09)
	localparam int LG_CL = 0;
	localparam int LG_OL = 1;
	// Reset values
	localparam logic [7:0]    SUBMODE_RST = 8'h00;
	localparam logic [1:0]    LEGACY_RST  = 2'h3;
	localparam logic [DW-1:0] FF_VOLT_RST = 16'h03E8;
	localparam logic [DW-1:0] KP_RST      = 16'h0064;
	localparam logic [DW-1:0] TN_RST      = 16'h0000;
	localparam logic [DW-1:0] EMAX_RST    = 16'h03E8;
	localparam logic [DW-1:0] YMAX_RST    = 16'h7FFF;
	localparam logic [23:0]   FB_MASK_RST = 24'h0000_00;
	// Scaling
	localparam longint PCT      = 100;
	localparam longint PERMILLE = 1000;
	typedef enum logic [3:0] {
		MD_NONE = 4'h0, MD_PP = 4'h1, MD_VL = 4'h2, MD_PV = 4'h3, MD_TQ = 4'h4,
		MD_HM = 4'h5, MD_IP = 4'h6, MD_CSP = 4'h7, MD_CSV = 4'h8, MD_CST = 4'h9,
		MD_CD = 4'hA
	} cpm_mode_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_POS  = 2'b01,
		ST_VEL  = 2'b11,
		ST_CUR  = 2'b10
	} cpm_state_e;
endpackage

// ==== tb/cpm_core_asserts.sv ====
// Port checks for the cascaded PI core
`timescale 1ns/1ps
module cpm_core_asserts
	import cpm_pkg::*;
(
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 clk_en,
	input wire logic                 ctrl_tick,
	input wire logic signed [DW-1:0] pwm_duty,
	input wire logic signed [DW-1:0] vel_setpoint,
	input wire logic signed [DW-1:0] cur_setpoint,
	input wire logic [1:0]           comm_sensor,
	input wire logic                 align_req,
	input wire logic [NS-1:0]        sensor_aligned,
	input wire logic                 cycle_done
);
	logic busy;
	wire  idle = !busy || cycle_done;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Done frees the core for a tick on that same edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy <= 1'b0;
		else if (clk_en && ctrl_tick && idle)
			busy <= 1'b1;
		else if (cycle_done)
			busy <= 1'b0;
	end
	sequence s_done_win;
		##[2:4] cycle_done;
	endsequence
	sequence s_tick_seen;
		$past(ctrl_tick, 2) || $past(ctrl_tick, 3) || $past(ctrl_tick, 4);
	endsequence
	a_tick_done: assert property (clk_en && ctrl_tick && idle |-> s_done_win)
		else $error("control cycle did not complete");
	a_done_pulse: assert property (cycle_done && clk_en |=> !cycle_done)
		else $error("done wider than one cycle");
	a_done_cause: assert property (cycle_done |-> s_tick_seen)
		else $error("done without a tick");
	a_pwm_hold: assert property (!cycle_done |-> $stable(pwm_duty))
		else $error("duty moved outside a cycle end");
	a_cursp_hold: assert property (!cycle_done |-> $stable(cur_setpoint))
		else $error("current set point moved outside a cycle end");
	a_vel_then_cur: assert property ($changed(vel_setpoint) |=> cycle_done)
		else $error("current loop did not follow velocity loop");
	a_commut_ok: assert property (cycle_done && !align_req && comm_sensor != 2'h0
		|-> sensor_aligned[comm_sensor])
		else $error("commutation from unaligned sensor");
	a_align_need: assert property (cycle_done && align_req |-> !sensor_aligned[comm_sensor])
		else $error("alignment requested with aligned sensor");
endmodule

// ==== tb/cpm_motor_model.sv ====
// Behavioural windings, Hall sensors and incremental encoder
`timescale 1ns/1ps
module cpm_motor_model
	import cpm_pkg::*;
#(
	parameter bit SLOW = 1'b0
)
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic signed [DW-1:0] pwm_duty,
	input  wire logic                 hall_ok,
	input  wire logic                 index_seen,
	output logic signed [DW-1:0]      cur_actual,
	output logic [NS-1:0][DW-1:0]     pos_fb,
	output logic [NS-1:0][DW-1:0]     vel_fb,
	output logic [NS-1:0]             sensor_aligned
);
	logic [DW-1:0] angle;
	// Slow windings settle halfway per cycle, like a large inductance
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_actual <= '0;
			angle      <= '0;
		end else begin
			cur_actual <= SLOW ? (cur_actual + (pwm_duty >>> 2)) >>> 1 : pwm_duty >>> 2;
			angle      <= angle + DW'(cur_actual >>> 4);
		end
	end
	assign pos_fb = {angle, angle & 16'hFF00, angle};
	assign vel_fb = {3{DW'(cur_actual >>> 4)}};
	// Hall is absolute; the encoder needs its index first
	assign sensor_aligned = {index_seen, hall_ok, 1'b0};
endmodule

// ==== tb/tb_cascaded_pi_motor_control.sv ====
// Self-checking bench for the cascaded PI core
`timescale 1ns/1ps
module tb_cascaded_pi_motor_control;
	import cpm_pkg::*;
	logic                  pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, ctrl_tick = 1'b0;
	logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic                  hall_ok = 1'b1, index_seen = 1'b0;
	logic [AW-1:0]         paddr = '0;
	logic [31:0]           pwdata = '0, prdata, rd;
	logic signed [DW-1:0]  pos_demand = '0, ramp_vel = '0, ramp_acc = '0, torque_demand = '0;
	logic signed [DW-1:0]  cur_actual, pwm_duty, vel_setpoint, cur_setpoint;
	logic [NS-1:0][DW-1:0] pos_fb, vel_fb;
	logic [NS-1:0]         sensor_aligned;
	logic [1:0]            comm_sensor;
	logic                  pready, pslverr, align_req, cycle_done, rerr;
	bit                    exp_p, exp_v;
	int                    errors = 0, num_checks = 0, kp, dev, ev, gain[2];
	localparam int LIM = 1000;
	localparam logic [AW-1:0] RA [5] = '{A_LEGACY, A_FF_VOLT, A_SUBMODE, A_FB_MASK, A_GAIN};
	localparam logic [31:0] RV [5] = '{32'h0000_0003, 32'h0000_03E8, '0, '0, 32'h0000_0064};
	localparam logic [23:0] MK [6] = '{24'h07_0000, 24'h05_0300, 24'h07_0600, 24'h07_0600,
		24'h04_0400, 24'h00_0000};
	localparam logic [2:0] SI [6] = '{3'h6, 3'h6, 3'h4, 3'h0, 3'h3, 3'h1};
	localparam logic [6:0] EX [6] = '{7'h54, 7'h2C, 7'h4A, 7'h4B, 7'h04, 7'h01};
	localparam int DEVS [4] = '{1000, -1000, 3000, -3000};
	localparam int TNS [2] = '{1, 4};
	cpm_core dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ctrl_tick, .pos_demand, .ramp_vel, .ramp_acc,
		.torque_demand, .pos_fb, .vel_fb, .sensor_aligned, .cur_actual, .pwm_duty,
		.vel_setpoint, .cur_setpoint, .comm_sensor, .align_req, .cycle_done);
	cpm_motor_model #(.SLOW(1'b1)) u_motor (.pclk, .presetn, .pwm_duty, .hall_ok,
		.index_seen, .cur_actual, .pos_fb, .vel_fb, .sensor_aligned);
	initial begin
		forever #10 pclk = ~pclk;
	end
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 50) begin
			errors++;
			summarize();
		end
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rst;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	// Deviation is set against the measured current so the loop error is exact
	task automatic tick(input int e);
		int n;
		n = 0;
		repeat (20) @(posedge pclk);
		torque_demand <= DW'(cur_actual + e);
		pos_demand <= DW'($urandom);
		ramp_vel <= DW'($urandom_range(400));
		ctrl_tick <= 1'b1;
		@(posedge pclk);
		ctrl_tick <= 1'b0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (cycle_done !== 1'b1 && n < 8);
		if (n >= 8) begin
			errors++;
			summarize();
		end
	endtask
	function automatic logic [AW-1:0] ga(input int l, input int f);
		return AW'(A_GAIN + l * GAIN_STEP + 4 * f);
	endfunction
	function automatic int pi_p(input int e, input int k);
		longint p;
		p = longint'(e) * k * LIM / (LIM * PCT);
		if (p > LIM) p = LIM;
		if (p < -LIM) p = -LIM;
		return int'(p);
	endfunction
	// Real torque mode isolates the current loop at the duty output
	task automatic cfg(input logic [31:0] leg, input int tn);
		apb(1'b1, A_LEGACY, leg);
		apb(1'b1, A_SUBMODE, 32'h0000_0021);
		apb(1'b1, A_OPMODE, 32'(MD_TQ));
		apb(1'b1, A_FB_MASK, 32'h0000_0700);
		apb(1'b1, A_FF_VOLT, '0);
		apb(1'b1, A_FF_ACC, 32'h0000_01F4);
		apb(1'b1, A_INERTIA, 32'h0000_03E8);
		apb(1'b1, ga(L_CUR, F_EMAX), 32'(LIM));
		apb(1'b1, ga(L_CUR, F_YMAX), 32'(LIM));
		apb(1'b1, ga(L_CUR, F_KP), 32'h0000_0064);
		apb(1'b1, ga(L_CUR, F_TN), 32'(tn));
		apb(1'b1, ga(L_CUR, F_LKP), 32'h0000_0032);
		apb(1'b1, ga(L_CUR, F_LTN), '0);
		hall_ok <= 1'b1;
		ramp_acc <= 16'h03E8;
	endtask
	initial begin
		void'($urandom(57289));
		rst();
		foreach (RA[i]) begin
			apb(1'b0, RA[i], '0);
			chk("reset value", rd, RV[i]);
		end
		apb(1'b0, 16'h0030, '0);
		chk("unmapped error", 32'(rerr), 32'h0000_0001);
		$display("test registers done");
		for (int m = 1; m <= 10; m++) begin
			for (int s = 0; s < 4; s++) begin
				apb(1'b1, A_SUBMODE, {26'h0, s[1], 3'h0, s[0], 1'b1});
				apb(1'b1, A_OPMODE, 32'(m));
				tick(0);
				apb(1'b0, A_STATUS, '0);
				exp_p = m inside {1, 5, 6, 7, 10} || (m inside {2, 3, 8} && s[0]);
				exp_v = !(m inside {4, 9} && s[1]);
				chk("position loop", 32'(rd[0]), 32'(exp_p));
				chk("velocity loop", 32'(rd[1]), 32'(exp_v));
			end
		end
		$display("test loop enables done");
		apb(1'b1, A_OPMODE, 32'(MD_PP));
		foreach (MK[i]) begin
			apb(1'b1, A_SUBMODE, {27'h0, SI[i][0], 4'h1});
			apb(1'b1, A_FB_MASK, 32'(MK[i]));
			hall_ok <= SI[i][2];
			index_seen <= SI[i][1];
			tick(0);
			apb(1'b0, A_STATUS, '0);
			if (i < 4) chk("sensor select", 32'({rd[3:2], rd[5:4]}), 32'(EX[i][6:3]));
			chk("commutation", 32'({comm_sensor, align_req}), 32'(EX[i][2:0]));
		end
		$display("test feedback mask done");
		for (int k = 0; k < 2; k++) begin
			rst();
			cfg(k == 0 ? 32'h0000_0003 : '0, 0);
			kp = (k == 0) ? 50 : 100;
			for (int j = 0; j < 6; j++) begin
				dev = (j < 4) ? DEVS[j] : int'($urandom_range(1600)) - 800;
				tick(dev);
				chk("duty", 32'(pwm_duty), 32'(pi_p(dev, kp)));
				chk("current set point", 32'(cur_setpoint), 32'(torque_demand));
			end
		end
		$display("test current loop done");
		// Zero position and current gains leave only the feed-forward paths visible
		rst();
		cfg('0, 0);
		apb(1'b1, A_OPMODE, 32'(MD_PV));
		apb(1'b1, A_FF_VEL, 32'h0000_01F4);
		apb(1'b1, ga(L_POS, F_KP), '0);
		apb(1'b1, ga(L_VEL, F_YMAX), 32'(LIM));
		apb(1'b1, ga(L_CUR, F_KP), '0);
		for (int s = 0; s < 3; s++) begin
			apb(1'b1, A_SUBMODE, 32'(s == 2 ? 2 : 1 + 2 * s));
			tick(0);
			ev = (s == 0) ? int'(ramp_vel) : int'(ramp_vel) * 500 / 1000;
			chk("velocity set point", 32'(vel_setpoint), 32'(ev));
			// Acceleration 1000 at 500 permille and unit inertia adds 500
			chk("current set point", 32'(cur_setpoint), 32'(s == 2 ? LIM : ev + 500));
		end
		apb(1'b1, A_RATED_V, 32'h0000_0190);
		for (int v = 0; v < 2; v++) begin
			apb(1'b1, A_FF_VOLT, 32'(500 * v));
			tick(0);
			chk("voltage feed-forward", 32'(pwm_duty), 32'(400 * 500 * v / 1000));
		end
		$display("test feed-forward done");
		foreach (TNS[i]) begin
			rst();
			cfg('0, TNS[i]);
			tick(200);
			tick(200);
			gain[i] = int'(pwm_duty);
		end
		chk("integral weight", 32'(gain[0] > gain[1]), 32'h0000_0001);
		chk("integral growth", 32'(gain[1] > 200), 32'h0000_0001);
		@(posedge pclk);
		clk_en <= 1'b0;
		apb(1'b1, A_FF_VOLT, 32'h0000_0007);
		clk_en <= 1'b1;
		apb(1'b0, A_FF_VOLT, '0);
		chk("gated write", rd, '0);
		$display("test integral done");
		summarize();
	end
endmodule
bind cpm_core cpm_core_asserts u_chk (.pclk, .presetn, .clk_en, .ctrl_tick, .pwm_duty,
	.vel_setpoint, .cur_setpoint, .comm_sensor, .align_req, .sensor_aligned, .cycle_done);
